// file: slave_event_time_id_pdram_consts.vh
`ifndef SLAVE_EVENT_TIME_ID_PDRAM_CONSTS_VH
`define SLAVE_EVENT_TIME_ID_PDRAM_CONSTS_VH
// ********************************************************
// register offsets (byte addresses)
// ********************************************************
`define FRAME_EVT_TIME_OFS    16'h09F0
`define HOST_START_TIME_OFS   16'h09F8
`define HOST_CHANGE_TIME_OFS  16'h09FC
`define PRODUCT_IDENTITY_OFS        16'h0E00
`define VENDOR_IDENTITY_OFS         16'h0E08
`define PARAM_RAM_OFS         16'h0580
`define PDRAM_BASE            16'h1000
`define PDRAM_LAST            16'h4FFF
// ********************************************************
// field positions and reset values
// ********************************************************
`define EVT_TIME_RESET        32'h0000_0000
`define SHADOW_MSB            31
`define SHADOW_LSB            8
`define VENDOR_COMPANY_MSB    23
`define VENDOR_DEPT_LSB       24
`define VENDOR_DEPT_MSB       31
`define MFC_LV_IO_COUNT       16
`define MFC_HV_IO_COUNT       8
`endif

// file: event_time_latch.v
`include "slave_event_time_id_pdram_consts.vh"

// ********************************************************
// one event time register with a shadow per reader side
// ********************************************************
module event_time_latch (
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  // capture request and time
  input  wire        capture,
  input  wire [31:0] time_in,
  // low-byte read strobes of each side
  input  wire        fs_low_rd,
  input  wire        hs_low_rd,
  // values seen by each side
  output wire [31:0] fs_view,
  output wire [31:0] hs_view
);
  reg [31:0] stamp_reg;   // captured local time
  reg [23:0] fs_shad_reg; // frame-side frozen upper bits
  reg [23:0] hs_shad_reg; // host-side frozen upper bits

  // capture and freeze; separate shadows so one side cannot tear the other
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      stamp_reg   <= `EVT_TIME_RESET;
      fs_shad_reg <= 24'h000000;
      hs_shad_reg <= 24'h000000;
    end else begin
      if (capture) begin
        stamp_reg <= time_in;
      end
      if (fs_low_rd) begin
        fs_shad_reg <= stamp_reg[`SHADOW_MSB:`SHADOW_LSB];
      end
      if (hs_low_rd) begin
        hs_shad_reg <= stamp_reg[`SHADOW_MSB:`SHADOW_LSB];
      end
    end
  end

  // low byte is live, upper bytes come from the frozen copy
  assign fs_view = {fs_shad_reg, stamp_reg[7:0]};
  assign hs_view = {hs_shad_reg, stamp_reg[7:0]};
endmodule // event_time_latch

// file: slave_event_time_id_pdram_regs.v
`include "slave_event_time_id_pdram_consts.vh"

module slave_event_time_id_pdram_regs #(
  parameter PARAM_DEPTH    = 128,                    // parameter RAM bytes
  parameter PDRAM_BYTES    = 16384,                  // process RAM bytes
  parameter [31:0] PRODUCT_LO = 32'h1234_5678,       // arbitrary identity value
  parameter [31:0] PRODUCT_HI = 32'h0000_0000,       // arbitrary identity value
  parameter [23:0] VENDOR_COMPANY = 24'h00ABCD,      // arbitrary identity value
  parameter [7:0]  VENDOR_DEPT    = 8'h00,           // arbitrary identity value
  parameter [31:0] VENDOR_HI      = 32'h0000_0000    // arbitrary identity value
) (
  // clock and reset
  clk_sys,
  reset_n,
  // time base and events
  local_time,
  frame_start,
  frame_event,
  host_start_event,
  host_change_event,
  // eeprom loader
  eeprom_loaded,
  ee_wr_valid,
  ee_wr_addr,
  ee_wr_data,
  // frame-side access
  fs_addr,
  fs_rd,
  fs_wr,
  fs_wdata,
  fs_rdata,
  fs_rvalid,
  fs_refused,
  // host-side access
  hs_addr,
  hs_rd,
  hs_wr,
  hs_wdata,
  hs_rdata,
  hs_rvalid,
  hs_refused,
  // multifunction io configuration
  io_dir_cfg
);
  localparam IO_COUNT = `MFC_LV_IO_COUNT + `MFC_HV_IO_COUNT;

  input  wire                clk_sys;
  input  wire                reset_n;
  input  wire [31:0]         local_time;
  input  wire                frame_start;
  input  wire                frame_event;
  input  wire                host_start_event;
  input  wire                host_change_event;
  input  wire                eeprom_loaded;
  input  wire                ee_wr_valid;
  input  wire [15:0]         ee_wr_addr;
  input  wire [7:0]          ee_wr_data;
  input  wire [15:0]         fs_addr;
  input  wire                fs_rd;
  input  wire                fs_wr;
  input  wire [7:0]          fs_wdata;
  output reg  [7:0]          fs_rdata;
  output reg                 fs_rvalid;
  output reg                 fs_refused;
  input  wire [15:0]         hs_addr;
  input  wire                hs_rd;
  input  wire                hs_wr;
  input  wire [7:0]          hs_wdata;
  output reg  [7:0]          hs_rdata;
  output reg                 hs_rvalid;
  output reg                 hs_refused;
  output reg  [IO_COUNT-1:0] io_dir_cfg;

  // ********************************************************
  // storage
  // ********************************************************
  reg [7:0]  pdram [0:PDRAM_BYTES-1];  // process data RAM, no reset
  reg [7:0]  param_ram_reg [0:PARAM_DEPTH-1]; // parameter RAM
  reg [31:0] frame_t0_reg;             // local time at current frame start

  wire [31:0] fs_view [0:2];           // per-register frame-side views
  wire [31:0] hs_view [0:2];           // per-register host-side views
  wire [2:0]  capture;                 // per-register capture strobes
  wire [63:0] product_identity;              // product identity word
  wire [63:0] vendor_identity;               // vendor identity word

  assign capture[0] = frame_event;
  assign capture[1] = host_start_event;
  assign capture[2] = host_change_event;
  assign product_identity = {PRODUCT_HI, PRODUCT_LO};
  assign vendor_identity  = {VENDOR_HI, VENDOR_DEPT, VENDOR_COMPANY};

  // ********************************************************
  // address decode helpers
  // ********************************************************
  // base offset of event register n
  function [15:0] evt_base;
    input integer n;
    begin
      case (n)
        0:       evt_base = `FRAME_EVT_TIME_OFS;
        1:       evt_base = `HOST_START_TIME_OFS;
        default: evt_base = `HOST_CHANGE_TIME_OFS;
      endcase
    end
  endfunction

  // address inside the process RAM window
  function in_pdram;
    input [15:0] a;
    begin
      in_pdram = (a >= `PDRAM_BASE) && (a <= `PDRAM_LAST);
    end
  endfunction

  // address inside the parameter RAM window
  function in_param;
    input [15:0] a;
    begin
      in_param = (a >= `PARAM_RAM_OFS) && (a < `PARAM_RAM_OFS + PARAM_DEPTH);
    end
  endfunction

  // read-only registers of this block (times and identities)
  function in_ro;
    input [15:0] a;
    begin
      in_ro = (a[15:2] == `FRAME_EVT_TIME_OFS >> 2) ||
              (a[15:2] == `HOST_START_TIME_OFS >> 2) ||
              (a[15:2] == `HOST_CHANGE_TIME_OFS >> 2) ||
              (a[15:4] == `PRODUCT_IDENTITY_OFS >> 4);
    end
  endfunction

  // ********************************************************
  // event time registers
  // ********************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_evt
      event_time_latch u_latch (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .capture   (capture[g]),
        .time_in   ((g == 0) ? frame_t0_reg : local_time),
        .fs_low_rd (fs_rd && (fs_addr == evt_base(g))),
        .hs_low_rd (hs_rd && (hs_addr == evt_base(g))),
        .fs_view   (fs_view[g]),
        .hs_view   (hs_view[g])
      );
    end
  endgenerate

  // frame start time is held until the frame's event decision
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      frame_t0_reg <= 32'h0000_0000;
    end else if (frame_start) begin
      frame_t0_reg <= local_time;
    end
  end

  // ********************************************************
  // read mux shared by both sides
  // ********************************************************
  // returns {hit, byte}; the v0-v2 views passed in pick the shadow set, side changes nothing
  function [8:0] read_byte;
    input [15:0]  a;
    input         side;
    input [31:0]  v0;
    input [31:0]  v1;
    input [31:0]  v2;
    input [7:0]   pd;
    input [7:0]   pr;
    input         loaded;
    reg   [31:0]  w;
    begin
      read_byte = 9'h000;
      w = 32'h0000_0000;
      if (a[15:2] == `FRAME_EVT_TIME_OFS >> 2) begin
        w = v0;
      end else if (a[15:2] == `HOST_START_TIME_OFS >> 2) begin
        w = v1;
      end else if (a[15:2] == `HOST_CHANGE_TIME_OFS >> 2) begin
        w = v2;
      end
      if (a[15:3] == `PRODUCT_IDENTITY_OFS >> 3) begin
        read_byte = {1'b1, product_identity[a[2:0]*8 +: 8]};
      end else if (a[15:3] == `VENDOR_IDENTITY_OFS >> 3) begin
        read_byte = {1'b1, vendor_identity[a[2:0]*8 +: 8]};
      end else if (in_ro(a)) begin
        read_byte = {1'b1, w[a[1:0]*8 +: 8]};
      end else if (in_param(a)) begin
        read_byte = {1'b1, pr};
      end else if (in_pdram(a) && loaded) begin
        read_byte = {1'b1, pd};
      end
      if (side) begin
        read_byte = read_byte; // both sides share the same map
      end
    end
  endfunction

  wire [15:0] fs_pd_idx = fs_addr - `PDRAM_BASE; // process RAM index
  wire [15:0] hs_pd_idx = hs_addr - `PDRAM_BASE;
  wire [15:0] fs_pr_idx = fs_addr - `PARAM_RAM_OFS; // parameter RAM index
  wire [15:0] hs_pr_idx = hs_addr - `PARAM_RAM_OFS;
  wire [7:0]  fs_pd_q = in_pdram(fs_addr) ? pdram[fs_pd_idx[13:0]] : 8'h00;
  wire [7:0]  hs_pd_q = in_pdram(hs_addr) ? pdram[hs_pd_idx[13:0]] : 8'h00;
  wire [7:0]  fs_pr_q = in_param(fs_addr) ? param_ram_reg[fs_pr_idx[6:0]] : 8'h00;
  wire [7:0]  hs_pr_q = in_param(hs_addr) ? param_ram_reg[hs_pr_idx[6:0]] : 8'h00;
  wire [8:0]  fs_rb = read_byte(fs_addr, 1'b0, fs_view[0], fs_view[1], fs_view[2],
                                fs_pd_q, fs_pr_q, eeprom_loaded);
  wire [8:0]  hs_rb = read_byte(hs_addr, 1'b1, hs_view[0], hs_view[1], hs_view[2],
                                hs_pd_q, hs_pr_q, eeprom_loaded);
  wire        fs_wr_ok = in_param(fs_addr) || (in_pdram(fs_addr) && eeprom_loaded);
  wire        hs_wr_ok = in_param(hs_addr) || (in_pdram(hs_addr) && eeprom_loaded);

  // ********************************************************
  // read answers and refusals
  // ********************************************************
  // answer one cycle after the strobe; refused marks unmapped, locked or read-only
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      fs_rdata   <= 8'h00;
      fs_rvalid  <= 1'b0;
      fs_refused <= 1'b0;
      hs_rdata   <= 8'h00;
      hs_rvalid  <= 1'b0;
      hs_refused <= 1'b0;
    end else begin
      fs_rvalid  <= fs_rd;
      hs_rvalid  <= hs_rd;
      fs_rdata   <= fs_rd ? fs_rb[7:0] : 8'h00;
      hs_rdata   <= hs_rd ? hs_rb[7:0] : 8'h00;
      fs_refused <= (fs_rd && !fs_rb[8]) || (fs_wr && !fs_wr_ok);
      hs_refused <= (hs_rd && !hs_rb[8]) || (hs_wr && !hs_wr_ok);
    end
  end

  // ********************************************************
  // process data RAM writes
  // ********************************************************
  // no reset on purpose: contents are undefined after power-up
  // same address from both sides in one cycle: frame side lands last and wins
  always @(posedge clk_sys) begin
    if (hs_wr && in_pdram(hs_addr) && eeprom_loaded) begin
      pdram[hs_pd_idx[13:0]] <= hs_wdata;
    end
    if (fs_wr && in_pdram(fs_addr) && eeprom_loaded) begin
      pdram[fs_pd_idx[13:0]] <= fs_wdata;
    end
  end

  // ********************************************************
  // parameter RAM: eeprom copy, then writable by both sides
  // ********************************************************
  // eeprom loader has lowest priority; frame side highest
  integer i;
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      for (i = 0; i < PARAM_DEPTH; i = i + 1) begin
        param_ram_reg[i] <= 8'h00;
      end
    end else begin
      if (ee_wr_valid && in_param(ee_wr_addr)) begin
        param_ram_reg[ee_wr_addr[6:0] - 7'h00] <= ee_wr_data;
      end
      if (hs_wr && in_param(hs_addr)) begin
        param_ram_reg[hs_pr_idx[6:0]] <= hs_wdata;
      end
      if (fs_wr && in_param(fs_addr)) begin
        param_ram_reg[fs_pr_idx[6:0]] <= fs_wdata;
      end
    end
  end

  // ********************************************************
  // io direction configuration for the multifunction block
  // ********************************************************
  // first three parameter bytes give one direction bit per io
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      io_dir_cfg <= {IO_COUNT{1'b0}};
    end else begin
      io_dir_cfg <= {param_ram_reg[2], param_ram_reg[1], param_ram_reg[0]};
    end
  end
endmodule // slave_event_time_id_pdram_regs

// file: slave_event_time_id_pdram_regs_checker.sv
// ****************
// access checker
// ****************
module regs_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        eeprom_loaded,
  // frame side
  input wire logic [15:0] fs_addr,
  input wire logic        fs_rd,
  input wire logic        fs_wr,
  input wire logic [7:0]  fs_rdata,
  input wire logic        fs_rvalid,
  input wire logic        fs_refused,
  // host side
  input wire logic        hs_rd,
  input wire logic        hs_wr,
  input wire logic        hs_rvalid,
  input wire logic        hs_refused
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // process ram window and read-only time or identity words
  wire pd_f = (fs_addr >= 16'h1000) && (fs_addr <= 16'h4FFF);
  wire ro_f = (fs_addr[15:4] == 12'h09F) || (fs_addr[15:4] == 12'h0E0);
  sequence s_answer;
    fs_rvalid || fs_refused;
  endsequence
  sequence s_data;
    fs_rvalid && !fs_refused;
  endsequence
  a_fs_read_answer: assert property (fs_rd |=> s_answer) else $error("read unanswered");
  a_fs_idle_quiet: assert property (!fs_rd && !fs_wr |=> !fs_rvalid && !fs_refused) else $error("stray answer");
  a_hs_idle_quiet: assert property (!hs_rd && !hs_wr |=> !hs_rvalid && !hs_refused) else $error("stray answer");
  a_rdata_zero: assert property (!fs_rvalid |-> fs_rdata == 8'h00) else $error("data without read");
  a_pd_gated: assert property (fs_rd && pd_f && !eeprom_loaded |=> fs_refused && fs_rdata == 8'h00) else $error("ram open");
  a_pd_open: assert property (fs_rd && !fs_wr && pd_f && eeprom_loaded |=> s_data) else $error("ram shut");
  a_pd_end_refused: assert property (fs_rd && fs_addr > 16'h4FFF |=> fs_refused) else $error("past ram end");
  a_ro_write: assert property (fs_wr && ro_f |=> fs_refused) else $error("read-only write taken");
endmodule // regs_checker

bind slave_event_time_id_pdram_regs regs_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .eeprom_loaded(eeprom_loaded), .fs_addr(fs_addr), .fs_rd(fs_rd), .fs_wr(fs_wr), .fs_rdata(fs_rdata),
  .fs_rvalid(fs_rvalid), .fs_refused(fs_refused), .hs_rd(hs_rd), .hs_wr(hs_wr), .hs_rvalid(hs_rvalid),
  .hs_refused(hs_refused));

// file: time_eeprom_model.sv
// ****************
// far side: time base and eeprom copy
// ****************
module time_eeprom_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        go,
  // time and eeprom copy
  output logic      [31:0] local_time,
  output logic             eeprom_loaded,
  output logic             ee_wr_valid,
  output logic      [15:0] ee_wr_addr,
  output logic      [7:0]  ee_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] n_reg; // bytes copied so far
  // odd step so every byte of the time moves each cycle
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      {local_time, eeprom_loaded, ee_wr_valid, ee_wr_addr, ee_wr_data, n_reg} <= '0;
    end else begin
      local_time  <= local_time + 32'h0101_0103;
      ee_wr_valid <= 1'b0;
      if (go && n_reg == 2'd3) begin // copy over: status good
        eeprom_loaded <= 1'b1;
      end else if (go && !eeprom_loaded) begin
        ee_wr_valid <= 1'b1;
        ee_wr_addr  <= 16'h0580 + {14'h0, n_reg};
        ee_wr_data  <= {n_reg, 6'h15};
        n_reg       <= n_reg + 2'd1;
      end
    end
  end
endmodule // time_eeprom_model

// file: test_slave_event_time_id_pdram_regs.sv
module test_slave_event_time_id_pdram_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] P_LO = 32'h5EED_0101; // arbitrary identity value
  localparam logic [31:0] P_HI = 32'h0000_0007; // arbitrary identity value
  localparam logic [31:0] V_LO = 32'h4B12_3456; // arbitrary identity value
  localparam logic [31:0] V_HI = 32'h0000_0003; // arbitrary identity value
  localparam logic [9:0]  NOPE = 10'h100;       // refused write, no data
  localparam logic [9:0]  NOPE_RD = 10'h300;    // refused read: answered with zero data
  logic        clk_sys, reset_n, go, frame_start, frame_event, host_start_event, host_change_event;
  logic        fs_rd, fs_wr, hs_rd, hs_wr, fs_rvalid, fs_refused, hs_rvalid, hs_refused;
  logic        eeprom_loaded, ee_wr_valid;
  logic [15:0] ee_wr_addr, fs_addr, hs_addr, a;
  logic [7:0]  ee_wr_data, fs_wdata, hs_wdata, fs_rdata, hs_rdata, d;
  logic [31:0] local_time, t1, t2, t3, seed;
  logic [23:0] io_dir_cfg;
  logic [9:0]  fq[$], hq[$]; // expected {rvalid, refused, rdata}
  int          miscompares, n_tests, cyc;

  time_eeprom_model far (.clk_sys(clk_sys), .reset_n(reset_n), .go(go), .local_time(local_time),
    .eeprom_loaded(eeprom_loaded), .ee_wr_valid(ee_wr_valid), .ee_wr_addr(ee_wr_addr), .ee_wr_data(ee_wr_data));
  slave_event_time_id_pdram_regs #(.PRODUCT_LO(P_LO), .PRODUCT_HI(P_HI), .VENDOR_COMPANY(V_LO[23:0]),
    .VENDOR_DEPT(V_LO[31:24]), .VENDOR_HI(V_HI)) uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .local_time(local_time), .frame_start(frame_start), .frame_event(frame_event),
    .host_start_event(host_start_event), .host_change_event(host_change_event), .eeprom_loaded(eeprom_loaded),
    .ee_wr_valid(ee_wr_valid), .ee_wr_addr(ee_wr_addr), .ee_wr_data(ee_wr_data), .fs_addr(fs_addr),
    .fs_rd(fs_rd), .fs_wr(fs_wr), .fs_wdata(fs_wdata), .fs_rdata(fs_rdata), .fs_rvalid(fs_rvalid),
    .fs_refused(fs_refused), .hs_addr(hs_addr), .hs_rd(hs_rd), .hs_wr(hs_wr), .hs_wdata(hs_wdata),
    .hs_rdata(hs_rdata), .hs_rvalid(hs_rvalid), .hs_refused(hs_refused), .io_dir_cfg(io_dir_cfg));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one-cycle byte request; an answer is expected for reads and refusals
  task automatic acc(input bit hs, input bit rd, input bit wr, input logic [15:0] ad,
                     input logic [7:0] wd, input logic [9:0] ex);
    @(posedge clk_sys);
    #2;
    if (hs) begin
      {hs_rd, hs_wr, hs_addr, hs_wdata} = {rd, wr, ad, wd};
      if (rd || ex[8]) hq.push_back(ex);
    end else begin
      {fs_rd, fs_wr, fs_addr, fs_wdata} = {rd, wr, ad, wd};
      if (rd || ex[8]) fq.push_back(ex);
    end
    @(posedge clk_sys);
    #2;
    {fs_rd, fs_wr, hs_rd, hs_wr} = 4'h0;
  endtask

  task automatic rd32(input bit hs, input logic [15:0] ad, input logic [31:0] v);
    for (int k = 0; k < 4; k++) acc(hs, 1'b1, 1'b0, ad + 16'(k), 8'h00, {2'b10, v[8*k +: 8]});
  endtask

  // event pulse k: frame start, frame event, host start, host change
  task automatic ev(input int k, output logic [31:0] t);
    @(posedge clk_sys);
    #2;
    t = local_time;
    {frame_start, frame_event, host_start_event, host_change_event} = 4'h8 >> k;
    @(posedge clk_sys);
    #2;
    {frame_start, frame_event, host_start_event, host_change_event} = 4'h0;
  endtask

  // ****************
  // answer monitor: oldest note against each answer
  // ****************
  always @(negedge clk_sys) begin
    if (fs_rvalid || fs_refused) chk({fs_rvalid, fs_refused, fs_rdata}, fq.size() ? fq.pop_front() : 10'h3FF);
    if (hs_rvalid || hs_refused) chk({hs_rvalid, hs_refused, hs_rdata}, hq.size() ? hq.pop_front() : 10'h3FF);
  end

  // hang guard, well above the roughly 160 cycles needed
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      summarize;
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    {reset_n, go, frame_start, frame_event, host_start_event, host_change_event} = 6'h0;
    {fs_rd, fs_wr, hs_rd, hs_wr, fs_addr, hs_addr, fs_wdata, hs_wdata} = '0;
    seed = 32'hccb7;
    repeat (2) @(posedge clk_sys);
    #2 reset_n = 1'b1;
    acc(0, 1, 0, 16'h1000, 8'h00, NOPE_RD);
    acc(1, 0, 1, 16'h4FFF, 8'h5A, NOPE);
    $display("gated ram done");
    go = 1'b1;
    for (int i = 0; i < 20 && eeprom_loaded !== 1'b1; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    #2 chk(io_dir_cfg, 24'h955515);
    acc(1, 0, 1, 16'h0581, 8'h3C, 10'h0);
    acc(0, 0, 1, 16'h0582, 8'hC3, 10'h0);
    @(posedge clk_sys);
    #2 chk(io_dir_cfg, 24'hC33C15);
    $display("parameter ram done");
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 16'h4FFF : 16'h1000 + 16'($random(seed) & 32'h3FFF);
      d = 8'($random(seed));
      acc(i[0], 0, 1, a, d, 10'h0);
      acc(!i[0], 1, 0, a, 8'h00, {2'b10, d});
    end
    acc(0, 1, 0, 16'h5000, 8'h00, NOPE_RD);
    acc(1, 1, 0, 16'h09F4, 8'h00, NOPE_RD);
    $display("process ram done");
    ev(0, t1);
    ev(1, t3);
    rd32(0, 16'h09F0, t1);
    ev(2, t2);
    rd32(1, 16'h09F8, t2);
    ev(3, t2);
    rd32(1, 16'h09FC, t2);
    $display("capture done");
    ev(0, t1);
    ev(1, t3);
    acc(0, 1, 0, 16'h09F0, 8'h00, {2'b10, t1[7:0]});
    ev(0, t2);
    ev(1, t3);
    for (int k = 1; k < 4; k++) acc(0, 1, 0, 16'h09F0 + 16'(k), 8'h00, {2'b10, t1[8*k +: 8]});
    rd32(1, 16'h09F0, t2);
    $display("shadow done");
    acc(0, 0, 1, 16'h09F0, 8'hFF, NOPE);
    acc(1, 0, 1, 16'h0E08, 8'hFF, NOPE);
    rd32(1, 16'h09F0, t2);
    rd32(1, 16'h0E08, V_LO);
    rd32(0, 16'h0E00, P_LO);
    rd32(0, 16'h0E04, P_HI);
    rd32(1, 16'h0E0C, V_HI);
    $display("identity done");
    repeat (2) @(posedge clk_sys);
    #2 chk(fq.size() + hq.size(), 0);
    summarize;
  end
endmodule // test_slave_event_time_id_pdram_regs
